// File: inc/dsm_pkg.sv
// Constants shared by the loop status and mode pin logic.
// Assumes a single 10 MHz core clock and an active-low asynchronous reset.
package dsm_pkg;

  // ----------------------------------------------------------------------
  // Operating mode codes
  // ----------------------------------------------------------------------
  // Two-bit mode code as driven on the mode pick pins.
  typedef enum logic [1:0] {
    DSM_MODE_NORMAL   = 2'b00,
    DSM_MODE_HOLDOVER = 2'b01,
    DSM_MODE_FREERUN  = 2'b10,
    DSM_MODE_AUTO     = 2'b11
  } dsm_mode_e;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned RESET_HOLD_MS   = 3;
  // Least time, rounded up to whole cycles.
  localparam int unsigned RESET_HOLD_CYC  = (RESET_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam int unsigned NUM_REFS        = 3;
  localparam int unsigned SRC_A           = 0;
  localparam int unsigned SRC_B           = 1;
  localparam int unsigned SRC_C           = 2;

  // Out-of-range limit per application code, in ppm.
  localparam logic [7:0] OOR_LIMIT_APP0 = 8'h0C;
  localparam logic [7:0] OOR_LIMIT_APP1 = 8'h09;
  localparam logic [7:0] OOR_LIMIT_APP2 = 8'h14;

  // Reset value of the stored corrector delay.
  localparam logic [15:0] TEC_RESET = 16'h0000;

endpackage : dsm_pkg

// File: src/dsm_sync.sv
// Two-flop level synchroniser for a bus of slow control pins.
// Assumes the inputs are quasi-static levels from board logic.
module dsm_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Level in and synchronised level out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : dsm_sync

// File: src/dsm_status_pins.sv
// Status flag and mode control pin logic of the timing loop.
// Assumes core_clk at 10 MHz, lock and reference monitor results from the loop core,
// and board logic driving the select pins as static levels.
//
// Overview of operation
// RQ1 - freq_acquired_flag is high while the loop is frequency locked to the selected source.
// RQ2 - retained_freq_flag is high exactly while the loop is in holdover.
// RQ3 - Each source bad flag rises when that source is beyond the application's range limit.
// RQ4 - A source bad flag also rises on abrupt phase or frequency steps of that source.
// RQ5 - With phase_keep_select low the stored corrector delay is kept on return to Normal.
// RQ6 - With phase_keep_select high a fresh corrector delay is measured on return to Normal.
// RQ7 - The phase_keep_select choice applies only when Normal resumes the same source.
// RQ8 - The operating mode is taken from the two mode pick pins as one two-bit code.
// RQ9 - After chip reset release the block holds a reset state for 3 ms, outputs disabled.
// RQ10 - Board logic drives the application pick pins together to set the range limits.
// RQ11 - All select levels are synchronised to core_clk before they are used.
module dsm_status_pins #(
  parameter int unsigned RESET_HOLD_CYC = dsm_pkg::RESET_HOLD_CYC
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Board select pins.
  input  wire logic        op_mode_pick0,
  input  wire logic        op_mode_pick1,
  input  wire logic [1:0]  app_limit_pick,
  input  wire logic        phase_keep_select,
  // Loop core status.
  input  wire logic        core_freq_locked,
  input  wire logic [1:0]  selected_source,
  input  wire logic [7:0]  src_a_offset_ppm,
  input  wire logic [7:0]  src_b_offset_ppm,
  input  wire logic [7:0]  src_c_offset_ppm,
  input  wire logic [2:0]  src_step_seen,
  input  wire logic [15:0] measured_delay,
  // Status flags.
  output logic             freq_acquired_flag,
  output logic             retained_freq_flag,
  output logic             source_a_bad_flag,
  output logic             source_b_bad_flag,
  output logic             source_c_bad_flag,
  // Loop core control.
  output logic [1:0]       active_mode,
  output logic [15:0]      corrector_delay,
  output logic             remeasure_pulse,
  output logic             outputs_enable,
  output logic             in_reset_state
);

  // ----------------------------------------------------------------------
  // Synchronised select pins
  // ----------------------------------------------------------------------
  logic [4:0] sel_sync;

  // Mode, application and phase keep pins cross into core_clk here.
  dsm_sync #(.W(5)) u_sync ( // RQ11
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({phase_keep_select, app_limit_pick, op_mode_pick1, op_mode_pick0}),
    .sync_out (sel_sync)
  );

  logic [1:0] mode_code;
  logic [1:0] app_code;
  logic       keep_sel;

  // Mode pins form one code, pick1 is the upper bit.
  assign mode_code = sel_sync[1:0]; // RQ8
  assign app_code  = sel_sync[3:2]; // RQ10
  assign keep_sel  = sel_sync[4];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DSM_ST_RESET = 2'b00,
    DSM_ST_RUN   = 2'b01
  } dsm_phase_e;

  typedef struct packed {
    dsm_phase_e  phase;
    logic [22:0] hold_cnt;
    logic [1:0]  mode;
    logic [1:0]  last_src;
    logic        lock;
    logic        hold;
    logic [2:0]  bad;
    logic [15:0] delay;
    logic        remeas;
  } dsm_state_s;

  dsm_state_s st_q;
  dsm_state_s st_d;

  // Range check of one source against the application limit.
  function automatic logic out_of_range(input logic [7:0] off, input logic [1:0] app);
    logic [7:0] lim;
    lim = dsm_pkg::OOR_LIMIT_APP2;
    case (app)
      2'b00:   lim = dsm_pkg::OOR_LIMIT_APP0;
      2'b01:   lim = dsm_pkg::OOR_LIMIT_APP1;
      default: lim = dsm_pkg::OOR_LIMIT_APP2;
    endcase
    return off > lim;
  endfunction : out_of_range

  logic leaving_idle;
  logic same_src;

  // Next state of the whole block.
  always_comb begin
    st_d         = st_q;
    st_d.remeas  = 1'b0;
    leaving_idle = 1'b0;
    same_src     = 1'b0;
    case (st_q.phase)
      DSM_ST_RESET: begin
        // Hold the reset state for the full count with outputs off.
        if (st_q.hold_cnt >= 23'(RESET_HOLD_CYC - 1)) begin // RQ9
          st_d.phase = DSM_ST_RUN;
        end else begin
          st_d.hold_cnt = st_q.hold_cnt + 23'h00_0001;
        end
      end
      DSM_ST_RUN: begin
        st_d.mode = mode_code; // RQ8
        st_d.hold = (mode_code == dsm_pkg::DSM_MODE_HOLDOVER); // RQ2
        st_d.lock = core_freq_locked && (mode_code == dsm_pkg::DSM_MODE_NORMAL
                    || mode_code == dsm_pkg::DSM_MODE_AUTO); // RQ1
        st_d.bad[dsm_pkg::SRC_A] = out_of_range(src_a_offset_ppm, app_code)
                                   | src_step_seen[dsm_pkg::SRC_A]; // RQ3 RQ4
        st_d.bad[dsm_pkg::SRC_B] = out_of_range(src_b_offset_ppm, app_code)
                                   | src_step_seen[dsm_pkg::SRC_B]; // RQ3 RQ4
        st_d.bad[dsm_pkg::SRC_C] = out_of_range(src_c_offset_ppm, app_code)
                                   | src_step_seen[dsm_pkg::SRC_C]; // RQ3 RQ4
        leaving_idle = (st_q.mode == dsm_pkg::DSM_MODE_HOLDOVER
                        || st_q.mode == dsm_pkg::DSM_MODE_FREERUN)
                       && mode_code == dsm_pkg::DSM_MODE_NORMAL;
        same_src = (selected_source == st_q.last_src);
        if (leaving_idle && same_src && keep_sel) begin // RQ5 RQ7
          // Fresh measurement keeps the output phase still.
          st_d.delay  = measured_delay; // RQ6
          st_d.remeas = 1'b1; // RQ6
        end else if (leaving_idle && !same_src) begin
          // On return to Normal a new source always gets its own delay.
          st_d.delay  = measured_delay;
          st_d.remeas = 1'b1;
        end
        // Low select with the same source leaves the stored delay untouched.
        if (mode_code == dsm_pkg::DSM_MODE_NORMAL) begin
          st_d.last_src = selected_source;
        end
      end
      default: begin
        st_d.phase = DSM_ST_RESET;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{phase: DSM_ST_RESET, hold_cnt: '0, mode: 2'b00, last_src: 2'b00,
                lock: 1'b0, hold: 1'b0, bad: 3'b000, delay: dsm_pkg::TEC_RESET,
                remeas: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from state.
  assign freq_acquired_flag = st_q.lock;
  assign retained_freq_flag = st_q.hold;
  assign source_a_bad_flag  = st_q.bad[dsm_pkg::SRC_A];
  assign source_b_bad_flag  = st_q.bad[dsm_pkg::SRC_B];
  assign source_c_bad_flag  = st_q.bad[dsm_pkg::SRC_C];
  assign active_mode        = st_q.mode;
  assign corrector_delay    = st_q.delay;
  assign remeasure_pulse    = st_q.remeas;
  assign in_reset_state     = (st_q.phase == DSM_ST_RESET);
  assign outputs_enable     = (st_q.phase == DSM_ST_RUN); // RQ9

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [22:0] chk_run_cnt;

  // Counts cycles spent in the reset state for the hold check.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_run_cnt <= '0;
    end else if (in_reset_state) begin
      chk_run_cnt <= chk_run_cnt + 23'h00_0001;
    end
  end

  a_reset_hold_len: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ9
    $rose(outputs_enable) |-> chk_run_cnt == 23'(RESET_HOLD_CYC))
    else $error("reset state ended at wrong count");

  a_reset_outputs_off: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ9
    in_reset_state |-> !outputs_enable && !freq_acquired_flag && !retained_freq_flag)
    else $error("outputs active during reset state");

  a_hold_flag_mode: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ2
    outputs_enable && $past(outputs_enable) && $past(in_reset_state, 1) == 1'b0
    |-> retained_freq_flag == ($past(mode_code) == dsm_pkg::DSM_MODE_HOLDOVER))
    else $error("holdover flag does not follow mode");

  a_lock_needs_core: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ1
    freq_acquired_flag |-> $past(core_freq_locked))
    else $error("lock flag without core lock");

  a_src_a_range: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ3
    !in_reset_state && out_of_range(src_a_offset_ppm, app_code) |=> source_a_bad_flag)
    else $error("source a out of range not flagged");

  a_src_step_flag: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ4
    !in_reset_state && src_step_seen[dsm_pkg::SRC_B] |=> source_b_bad_flag)
    else $error("source b step not flagged");

  a_delay_kept_low: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ5
    leaving_idle && same_src && !keep_sel |=> $stable(corrector_delay) && !remeasure_pulse)
    else $error("delay changed with keep select low");

  a_delay_fresh_high: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ6
    leaving_idle && same_src && keep_sel |=> remeasure_pulse
    && corrector_delay == $past(measured_delay))
    else $error("fresh delay not taken with keep select high");

  a_mode_from_pins: assert property (@(posedge core_clk) disable iff (!arst_n) // RQ8
    !in_reset_state |=> active_mode == $past({op_mode_pick1, op_mode_pick0}, 3)
    || !$stable(sel_sync[1:0]) || $past(in_reset_state, 3))
    else $error("mode does not follow pins");

endmodule : dsm_status_pins

// File: test/dsm_board_model.sv
// Board control model: drives the mode, application and phase keep pins.
// Assumes requests from the bench change only at core_clk rising edges.
module dsm_board_model (
  // Clock.
  input  wire logic       core_clk,
  // Requests from the bench.
  input  wire logic [1:0] req_mode,
  input  wire logic [1:0] req_app,
  input  wire logic       req_keep,
  // Pins to the block.
  output logic            op_mode_pick0,
  output logic            op_mode_pick1,
  output logic [1:0]      app_limit_pick,
  output logic            phase_keep_select
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both code bits move in the same edge so the block never sees half a code.
  always_ff @(posedge core_clk) begin
    {op_mode_pick1, op_mode_pick0} <= req_mode;
    app_limit_pick                 <= req_app;
    phase_keep_select              <= req_keep;
  end
endmodule : dsm_board_model

// File: test/dpll_status_and_mode_pins_tb.sv
// Self-checking bench for the status flag and mode pin logic.
// Assumes a short reset state parameter so the run stays brief.
module dpll_status_and_mode_pins_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RST_CYC = 20;
  typedef struct packed {logic [6:0] f; logic [15:0] d; logic [15:0] p;} dsm_note_s;
  logic core_clk = 1'b0, arst_n = 1'b0, core_freq_locked = 1'b0, req_keep = 1'b0, chk = 1'b0;
  logic [1:0] req_mode = 2'b00, req_app = 2'b00, selected_source = 2'b00, m, a;
  logic [7:0] src_a_offset_ppm = 8'h00, src_b_offset_ppm = 8'h00, src_c_offset_ppm = 8'h00;
  logic [2:0] src_step_seen = 3'b000;
  logic [15:0] measured_delay = 16'h0000, exp_delay = 16'h0000, exp_pulses = 16'h0000;
  logic [15:0] pulses = 16'h0000;
  logic [31:0] r = 32'h0000_f295;
  logic op_mode_pick0, op_mode_pick1, phase_keep_select, fa, rf, sa, sb, sc, rp, oe, irs;
  logic [1:0] app_limit_pick, active_mode, norm_src = 2'b00, new_src = 2'b00;
  logic [15:0] corrector_delay;
  logic [7:0] lim;
  dsm_note_s q[$];
  dsm_note_s n;
  int fail_count = 0, num_checks = 0;
  // Free running core clock, 100 ns period.
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  dsm_board_model u_dsm_board_model (.core_clk(core_clk), .req_mode(req_mode), .req_app(req_app),
    .req_keep(req_keep), .op_mode_pick0(op_mode_pick0), .op_mode_pick1(op_mode_pick1),
    .app_limit_pick(app_limit_pick), .phase_keep_select(phase_keep_select));
  dsm_status_pins #(.RESET_HOLD_CYC(RST_CYC)) u_dsm_status_pins (.core_clk(core_clk),
    .arst_n(arst_n), .op_mode_pick0(op_mode_pick0), .op_mode_pick1(op_mode_pick1),
    .app_limit_pick(app_limit_pick), .phase_keep_select(phase_keep_select),
    .core_freq_locked(core_freq_locked), .selected_source(selected_source),
    .src_a_offset_ppm(src_a_offset_ppm), .src_b_offset_ppm(src_b_offset_ppm),
    .src_c_offset_ppm(src_c_offset_ppm), .src_step_seen(src_step_seen),
    .measured_delay(measured_delay), .freq_acquired_flag(fa), .retained_freq_flag(rf),
    .source_a_bad_flag(sa), .source_b_bad_flag(sb), .source_c_bad_flag(sc),
    .active_mode(active_mode), .corrector_delay(corrector_delay), .remeasure_pulse(rp),
    .outputs_enable(oe), .in_reset_state(irs));
  // Galois shift register used as the random source.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction : lfsr
  task automatic cmp_flags(input string nm, input logic [6:0] e, input logic [6:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_flags
  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    cmp_word("reset_out", 16'h0000, {fa, rf, sa, sb, sc, corrector_delay[10:0]});
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp_word("reset_hold", 16'h0002, {14'h0000, irs, oe});
    repeat (RST_CYC + 4) @(posedge core_clk);
    cmp_word("reset_done", 16'h0001, {14'h0000, irs, oe});
    exp_delay = 16'h0000;
  endtask : do_reset
  // Counts reload pulses and compares each note when its result is ready.
  always @(posedge core_clk) begin : watch_outputs
    dsm_note_s got;
    if (rp === 1'b1) pulses <= pulses + 16'h0001;
    if (chk) begin
      got = q.pop_front();
      cmp_flags("flags", got.f, {active_mode, fa, rf, sa, sb, sc});
      cmp_word("delay", got.d, corrector_delay);
      cmp_word("pulses", got.p, pulses);
    end
  end
  // Watchdog cuts a hang short.
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
  // Random mode, range and step traffic with a mid-run reset.
  initial begin
    do_reset();
    for (int i = 0; i < 60; i++) begin
      r = lfsr(lfsr(r));
      m = r[1:0];
      a = r[3:2];
      @(posedge core_clk);
      if (i == 30) begin
        req_mode <= 2'b00;
        do_reset();
        m = 2'b00;
      end
      req_mode <= m;
      req_app <= a;
      req_keep <= r[4];
      core_freq_locked <= r[5];
      src_step_seen <= r[8:6];
      src_a_offset_ppm <= {3'b000, r[13:9]};
      src_b_offset_ppm <= {3'b000, r[18:14]};
      src_c_offset_ppm <= {3'b000, r[23:19]};
      measured_delay <= r[31:16];
      // The source may move in any mode; the block remembers it only while Normal is in effect.
      new_src = (r[25:24] == 2'b11) ? 2'b00 : r[25:24];
      selected_source <= new_src;
      // Return to Normal reloads with keep high, or always when the source differs.
      if (m == 2'b00 && (req_mode == 2'b01 || req_mode == 2'b10)
          && (r[4] || new_src != norm_src)) begin
        exp_delay = r[31:16];
        exp_pulses = exp_pulses + 16'h0001;
      end
      if (m == 2'b00 || req_mode == 2'b00) norm_src = new_src;
      lim = (a == 2'b00) ? dsm_pkg::OOR_LIMIT_APP0 :
            (a == 2'b01) ? dsm_pkg::OOR_LIMIT_APP1 : dsm_pkg::OOR_LIMIT_APP2;
      n.f = {m, r[5] && (m == 2'b00 || m == 2'b11), m == 2'b01,
             ({3'b000, r[13:9]} > lim) || r[6], ({3'b000, r[18:14]} > lim) || r[7],
             ({3'b000, r[23:19]} > lim) || r[8]};
      n.d = exp_delay;
      n.p = exp_pulses;
      repeat (8) @(posedge core_clk);
      q.push_back(n);
      chk <= 1'b1;
      @(posedge core_clk);
      chk <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    conclude();
  end
endmodule : dpll_status_and_mode_pins_tb
